// ### pesc_pkg.sv
// Package for the performance event select and count block
package pesc_pkg;

    // ****************************************
    // Event codes
    // ****************************************
    localparam logic [5:0] EV_INSTR_EXEC = 6'h16;
    localparam logic [5:0] EV_INSTR_SECOND = 6'h17;
    localparam logic [5:0] EV_BUS_CYCLE_CLKS = 6'h18;
    localparam logic [5:0] EV_WBUF_FULL_STALL = 6'h19;
    localparam logic [5:0] EV_READ_WAIT_STALL = 6'h1a;
    localparam logic [5:0] EV_EM_WRITE_STALL = 6'h1b;
    localparam logic [5:0] EV_LOCKED_CYCLE = 6'h1c;
    localparam logic [5:0] EV_IO_CYCLE = 6'h1d;
    localparam logic [5:0] EV_NC_READ = 6'h1e;
    localparam logic [5:0] EV_AGI_STALL = 6'h1f;
    localparam logic [5:0] EV_FLOPS = 6'h22;
    localparam logic [5:0] EV_BKPT_ZERO = 6'h23;
    localparam logic [5:0] EV_BKPT_THREE = 6'h26;
    localparam logic [5:0] EV_HW_MASKABLE_INTERRUPT_REQUEST = 6'h27;
    localparam logic [5:0] EV_DATA_RW = 6'h28;
    localparam logic [5:0] EV_DATA_MISS = 6'h29;
    localparam logic [5:0] EV_BUS_OWNERSHIP = 6'h2a;
    localparam logic [5:0] EV_MM_FIRST_PIPE = 6'h2b;

    // ****************************************
    // Widths and counts
    // ****************************************
    localparam int CODE_W = 6;
    localparam int INC_W = 3;
    localparam int FP_OPS_W = 3;
    localparam int FILL_BEATS = 4;
    localparam logic [2:0] FILL_LAST = 3'h3;
    localparam logic [2:0] FILL_ZERO = 3'h0;
    localparam logic [1:0] BKPT_BASE = 2'h0;

    // ****************************************
    // Event source bundle, one field per occurrence
    // ****************************************
    typedef struct packed {
        logic first_retire;      // Instruction completed in first pipe
        logic second_retire;     // Instruction completed in second pipe
        logic string_repeat;     // Retire is a repeat-string iteration past the first
        logic halt_instruction;  // Halt instruction retiring this clock
        logic halted;            // Core idling in halt state
        logic fault_invoke;      // Fault handler invoked
        logic maskable_interrupt_request_taken;        // Any interrupt or exception taken
        logic hw_maskable_interrupt_request_taken;     // Maskable or nonmaskable hardware interrupt taken
        logic bus_busy;          // Bus cycle in progress
        logic hold_acknowledge;
        logic address_hold_request;
        logic bus_backoff;
        logic wbuf_full_stall;
        logic io_access;         // Stalled access targets I/O space
        logic read_wait_stall;
        logic dtlb_miss_stall;
        logic fill_read_stall;   // Read not bypassed during line fill
        logic em_write_stall;
        logic bus_cycle_start;   // Address strobe of a new bus cycle
        logic cycle_restart;     // Start is a restart after back-off
        logic cycle_locked_read;
        logic split_cycle_flag;
        logic cycle_io;
        logic cycle_nc_read;
        logic agi_first;
        logic agi_second;
        logic [FP_OPS_W-1:0] fp_ops; // FP operations finished this clock
        logic fp_excluded_exc;   // Those ops raised an excluded exception
        logic [3:0] breakpoint_match_pins;
        logic bkpt_enabled;
        logic bkpt_code_second;  // Code match raised by second pipe
        logic [1:0] data_access; // Data accesses this clock
        logic [1:0] data_miss;   // Data cache misses this clock
        logic data_tlb_proc;     // Accesses belong to translation-miss work
        logic data_io;
        logic miss_same_line;    // Miss hits the line being filled
        logic burst_ready;
        logic private_bus_request;
        logic private_modified_snoop_hit;
        logic modified_line_snoop_hit;
        logic private_bus_grant;
    } pesc_events_t;

endpackage : pesc_pkg

// ### pesc_counter.sv
// One performance counter accumulating a per-clock increment
`timescale 1ns/1ps
`default_nettype none

module pesc_counter #(
    parameter int CNT_W = 40
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Increment
    input wire logic [pesc_pkg::INC_W-1:0] inc_i,
    // Count
    output logic [CNT_W-1:0] count_o
);

    logic [CNT_W-1:0] count_ff;

    // An increment wider than the count would be cut
    if (CNT_W < pesc_pkg::INC_W) begin : g_bad_width
        $error("pesc_counter: CNT_W narrower than increment");
    end

    // Wraps silently; software owns overflow handling
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_ff <= '0;
        end else begin
            count_ff <= count_ff + CNT_W'(inc_i);
        end
    end

    assign count_o = count_ff;

endmodule : pesc_counter

`default_nettype wire

// ### pesc_top.sv
// Event selection and increment logic for two performance counters
// Function
// - Code 16H adds instructions completed, two max
// - 16H also counts faults, interrupts, exceptions
// - Repeat string instruction counts once only
// - Halt instruction adds exactly one
// - Code 17H counts second pipe completions
// - 18H counts busy bus clocks incl holds
// - 19H counts write-buffer-full stalls, not I/O
// - 1AH counts data read waits incl misses
// - 1BH counts stalls writing E/M lines
// - 1CH counts locked reads; split counts two
// - 1DH counts I/O cycles; misaligned counts once
// - Back-off restarts not recounted for 1C-1E
// - 1EH counts noncacheable reads, not I/O
// - 1FH counts interlocks, both pipes add two
// - 22H counts FP ops, excluded exceptions skipped
// - 23H-26H count debug matches, disabled first-pipe
// - 27H counts hardware interrupts taken
// - 28H counts data accesses, two per clock
// - 29H counts misses, burst-fill repeats skipped
// - 2AH counter 0 counts ownership wait clocks
// - 2AH counter 1 counts ownership requests
`timescale 1ns/1ps
`default_nettype none

module pesc_top #(
    parameter int CNT_W = 40
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Event sources
    input wire pesc_pkg::pesc_events_t events_i,
    // Event selects
    input wire logic [pesc_pkg::CODE_W-1:0] sel0_i,
    input wire logic [pesc_pkg::CODE_W-1:0] sel1_i,
    // Counters
    output logic [CNT_W-1:0] count0_o,
    output logic [CNT_W-1:0] count1_o,
    output logic [pesc_pkg::INC_W-1:0] inc0_o,
    output logic [pesc_pkg::INC_W-1:0] inc1_o
);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (CNT_W < 8) begin : g_bad_width
        $error("pesc_top: CNT_W too small");
    end

    // ****************************************
    // Reset synchroniser
    // ****************************************
    logic rst_meta_ff;
    logic rst_n_ff;

    // Release is synchronous; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ****************************************
    // Per-event state
    // ****************************************
    logic [2:0] fill_beat_ff;
    logic fill_active_ff;
    logic own_wait_ff;
    logic own_req_prev_ff;
    logic halt_seen_ff;
    logic own_start;

    // Earliest of request or either modified-hit opens the wait
    assign own_start = events_i.private_bus_request
        | events_i.private_modified_snoop_hit
        | events_i.modified_line_snoop_hit;

    // Burst fill tracker: open on a miss, close on fourth ready
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            fill_active_ff <= 1'b0;
            fill_beat_ff <= pesc_pkg::FILL_ZERO;
        end else if (fill_active_ff) begin
            if (events_i.burst_ready) begin
                if (fill_beat_ff == pesc_pkg::FILL_LAST) begin
                    fill_active_ff <= 1'b0;
                    fill_beat_ff <= pesc_pkg::FILL_ZERO;
                end else begin
                    fill_beat_ff <= fill_beat_ff + 3'h1;
                end
            end
        end else if (|events_i.data_miss && !events_i.data_tlb_proc && !events_i.data_io) begin
            fill_active_ff <= 1'b1;
            fill_beat_ff <= pesc_pkg::FILL_ZERO;
        end
    end

    // Ownership wait: starts on earliest request or hit, ends on grant
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            own_wait_ff <= 1'b0;
        end else if (events_i.private_bus_grant) begin
            own_wait_ff <= 1'b0;
        end else if (own_start) begin
            own_wait_ff <= 1'b1;
        end
    end

    // Request edge history for the transfer count
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            own_req_prev_ff <= 1'b0;
        end else begin
            own_req_prev_ff <= events_i.private_bus_request;
        end
    end

    // Halt residency guard, so only the instruction itself counts
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            halt_seen_ff <= 1'b0;
        end else begin
            halt_seen_ff <= events_i.halted;
        end
    end

    // ****************************************
    // Shared per-code increment decode
    // ****************************************
    function automatic logic [pesc_pkg::INC_W-1:0] ev_inc(
        input logic [pesc_pkg::CODE_W-1:0] code,
        input logic second_counter,
        input pesc_pkg::pesc_events_t ev,
        input logic fill_on,
        input logic own_on,
        input logic req_prev,
        input logic halt_prev
    );
        logic [pesc_pkg::INC_W-1:0] inc;
        logic [pesc_pkg::INC_W-1:0] retire;
        logic fresh;
        logic [1:0] bidx;
        logic [1:0] miss_n;
        inc = '0;
        // Repeat iterations contribute nothing; halted residency masks only the first-pipe retire
        retire = 3'(ev.first_retire && !ev.string_repeat
            && !(ev.halted && halt_prev && !ev.halt_instruction))
            + 3'(ev.second_retire && !ev.string_repeat);
        fresh = ev.bus_cycle_start && !ev.cycle_restart;
        bidx = 2'(code - pesc_pkg::EV_BKPT_ZERO);
        miss_n = (fill_on && ev.miss_same_line) ? 2'h0 : ev.data_miss;
        unique case (code) inside
            pesc_pkg::EV_INSTR_EXEC: begin
                inc = retire + 3'(ev.fault_invoke) + 3'(ev.maskable_interrupt_request_taken);
            end
            pesc_pkg::EV_INSTR_SECOND: begin
                inc = 3'(ev.second_retire && !ev.string_repeat);
            end
            pesc_pkg::EV_BUS_CYCLE_CLKS: begin
                inc = 3'(ev.bus_busy || ev.hold_acknowledge
                    || ev.address_hold_request || ev.bus_backoff);
            end
            pesc_pkg::EV_WBUF_FULL_STALL: begin
                inc = 3'(ev.wbuf_full_stall && !ev.io_access);
            end
            pesc_pkg::EV_READ_WAIT_STALL: begin
                inc = 3'(ev.read_wait_stall || ev.dtlb_miss_stall
                    || ev.fill_read_stall);
            end
            pesc_pkg::EV_EM_WRITE_STALL: begin
                inc = 3'(ev.em_write_stall);
            end
            pesc_pkg::EV_LOCKED_CYCLE: begin
                if (fresh && ev.cycle_locked_read) begin
                    inc = ev.split_cycle_flag ? 3'h2 : 3'h1;
                end
            end
            pesc_pkg::EV_IO_CYCLE: begin
                inc = 3'(fresh && ev.cycle_io); // each bus cycle seen once
            end
            pesc_pkg::EV_NC_READ: begin
                inc = 3'(fresh && ev.cycle_nc_read && !ev.cycle_io);
            end
            pesc_pkg::EV_AGI_STALL: begin
                inc = 3'(ev.agi_first) + 3'(ev.agi_second);
            end
            pesc_pkg::EV_FLOPS: begin
                inc = ev.fp_excluded_exc ? 3'h0 : ev.fp_ops;
            end
            [pesc_pkg::EV_BKPT_ZERO:pesc_pkg::EV_BKPT_THREE]: begin
                // Second-pipe code matches dropped while breakpoints are off
                inc = 3'(ev.breakpoint_match_pins[bidx]
                    && (ev.bkpt_enabled || !ev.bkpt_code_second));
            end
            pesc_pkg::EV_HW_MASKABLE_INTERRUPT_REQUEST: begin
                inc = 3'(ev.hw_maskable_interrupt_request_taken);
            end
            pesc_pkg::EV_DATA_RW: begin
                if (!ev.data_tlb_proc && !ev.data_io) begin
                    inc = 3'(ev.data_access);
                end
            end
            pesc_pkg::EV_DATA_MISS: begin
                if (!ev.data_tlb_proc && !ev.data_io) begin
                    inc = 3'(miss_n);
                end
            end
            pesc_pkg::EV_BUS_OWNERSHIP: begin
                if (second_counter) begin
                    inc = 3'(ev.private_bus_request && !req_prev);
                end else begin
                    inc = 3'(own_on && !ev.private_bus_grant);
                end
            end
            default: begin
                inc = '0;
            end
        endcase
        return inc;
    endfunction : ev_inc

    // ****************************************
    // Counter lanes
    // ****************************************
    logic [pesc_pkg::INC_W-1:0] lane_inc [2];
    logic [CNT_W-1:0] lane_cnt [2];
    logic [pesc_pkg::CODE_W-1:0] lane_sel [2];

    assign lane_sel[0] = sel0_i;
    assign lane_sel[1] = sel1_i;

    for (genvar g = 0; g < 2; g++) begin : g_lane
        // Each lane decodes its own select every clock; all state goes in as
        // arguments so the assign re-evaluates whenever any of it moves
        assign lane_inc[g] = ev_inc(lane_sel[g], 1'(g), events_i, fill_active_ff,
            own_wait_ff | own_start, own_req_prev_ff, halt_seen_ff);

        pesc_counter #(
            .CNT_W(CNT_W)
        ) u_counter (
            .clk_i(clk_i),
            .rst_n_i(rst_n_ff),
            .inc_i(lane_inc[g]),
            .count_o(lane_cnt[g])
        );
    end

    assign count0_o = lane_cnt[0];
    assign count1_o = lane_cnt[1];
    assign inc0_o = lane_inc[0];
    assign inc1_o = lane_inc[1];

    // ****************************************
    // Assertions
    // ****************************************
    a_count_adds: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        ##1 $past(rst_n_ff) |-> count0_o == CNT_W'($past(count0_o) + CNT_W'($past(inc0_o))))
        else $error("counter 0 did not add its increment");

    a_instr_two: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i == pesc_pkg::EV_INSTR_EXEC && events_i.first_retire && events_i.second_retire
        && !events_i.string_repeat && !events_i.halted && !events_i.fault_invoke
        && !events_i.maskable_interrupt_request_taken |-> inc0_o == 3'h2)
        else $error("paired completion not counted as two");

    a_repeat_once: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel1_i == pesc_pkg::EV_INSTR_SECOND && events_i.string_repeat |-> inc1_o == 3'h0)
        else $error("repeat iteration counted");

    a_bus_clks: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i == pesc_pkg::EV_BUS_CYCLE_CLKS && events_i.bus_backoff |-> inc0_o == 3'h1)
        else $error("back-off clock not counted as bus clock");

    a_wbuf_io: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i == pesc_pkg::EV_WBUF_FULL_STALL && events_i.io_access |-> inc0_o == 3'h0)
        else $error("I/O stall counted");

    a_split_lock: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel1_i == pesc_pkg::EV_LOCKED_CYCLE && events_i.bus_cycle_start
        && !events_i.cycle_restart && events_i.cycle_locked_read
        && events_i.split_cycle_flag |-> inc1_o == 3'h2)
        else $error("split locked cycle not counted twice");

    a_no_recount: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel1_i == pesc_pkg::EV_IO_CYCLE && events_i.cycle_restart |-> inc1_o == 3'h0)
        else $error("restarted cycle recounted");

    a_agi_both: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel1_i == pesc_pkg::EV_AGI_STALL && events_i.agi_first && events_i.agi_second
        |-> inc1_o == 3'h2)
        else $error("dual interlock not counted twice");

    a_own_wait: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i == pesc_pkg::EV_BUS_OWNERSHIP && own_wait_ff && !events_i.private_bus_grant
        |-> inc0_o == 3'h1)
        else $error("ownership wait clock missed");

    a_own_xfer: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel1_i == pesc_pkg::EV_BUS_OWNERSHIP && events_i.private_bus_request
        ##1 sel1_i == pesc_pkg::EV_BUS_OWNERSHIP && events_i.private_bus_request
        |-> inc1_o == 3'h0)
        else $error("held request counted again");

    a_count1_adds: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        ##1 $past(rst_n_ff) |-> count1_o == CNT_W'($past(count1_o) + CNT_W'($past(inc1_o))))
        else $error("counter 1 did not add its increment");

    a_fault_maskable_interrupt_request: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i == pesc_pkg::EV_INSTR_EXEC && events_i.fault_invoke && events_i.maskable_interrupt_request_taken
        && !events_i.first_retire && !events_i.second_retire |-> inc0_o == 3'h2)
        else $error("fault and interrupt not counted");

    a_halt_once: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i == pesc_pkg::EV_INSTR_EXEC && events_i.halted && halt_seen_ff
        && !events_i.halt_instruction && !events_i.second_retire
        && !events_i.fault_invoke && !events_i.maskable_interrupt_request_taken |-> inc0_o == 3'h0)
        else $error("halted clock counted");

    a_second_only: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel1_i == pesc_pkg::EV_INSTR_SECOND && !events_i.second_retire |-> inc1_o == 3'h0)
        else $error("first pipe work counted on second pipe code");

    a_nc_no_io: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i == pesc_pkg::EV_NC_READ && events_i.cycle_io |-> inc0_o == 3'h0)
        else $error("I/O read counted as noncacheable");

    a_flops_skip: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i == pesc_pkg::EV_FLOPS && events_i.fp_excluded_exc |-> inc0_o == 3'h0)
        else $error("excepting FP ops counted");

    a_bkpt_gate: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel0_i inside {[pesc_pkg::EV_BKPT_ZERO:pesc_pkg::EV_BKPT_THREE]}
        && !events_i.bkpt_enabled && events_i.bkpt_code_second |-> inc0_o == 3'h0)
        else $error("second pipe code match counted");

    a_fill_skip: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        sel1_i == pesc_pkg::EV_DATA_MISS && fill_active_ff && events_i.miss_same_line
        |-> inc1_o == 3'h0)
        else $error("same-line miss counted during fill");

endmodule : pesc_top

`default_nettype wire

// ### pesc_src_model.sv
// Behavioural model of the core event sources that feed the two counters
`timescale 1ns/1ps
`default_nettype none

module pesc_src_model (
    // Clock
    input wire logic clk_i,
    // Event levels towards the counters
    output pesc_pkg::pesc_events_t events_o
);
    pesc_pkg::pesc_events_t ev_q;
    logic ready_q;

    // Quiet sources from time zero
    initial begin
        ev_q = '0;
        ready_q = 1'b0;
    end

    // Burst ready exists only inside a line fill, never left over from one
    always_comb begin
        events_o = ev_q;
        events_o.burst_ready = ready_q;
    end

    // Change levels just after an edge, with no wait
    task automatic hold(input pesc_pkg::pesc_events_t e, input logic r);
        ev_q = e;
        ready_q = r;
    endtask : hold

    // Hold one pattern for n clocks
    task automatic apply(input pesc_pkg::pesc_events_t e, input int n);
        hold(e, 1'b0);
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask : apply

    // Line fill: a miss, then four beats spaced by gap clocks; same-line
    // misses keep arriving until the last beat, as a stalled pipe would
    task automatic fill(input int gap);
        pesc_pkg::pesc_events_t m;
        m = '0;
        m.data_miss = 2'h1;
        apply(m, 1);
        m.miss_same_line = 1'b1;
        for (int b = 1; b <= pesc_pkg::FILL_BEATS; b++) begin
            repeat (gap) apply(m, 1);
            hold((b == pesc_pkg::FILL_BEATS) ? '0 : m, 1'b1);
            @(posedge clk_i);
            #1;
        end
        apply('0, 1);
    endtask : fill
endmodule : pesc_src_model
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the performance event select and count block
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [5:0] sel0 = 6'h00;
    logic [5:0] sel1 = 6'h00;
    logic [39:0] count0, count1, base0, base1;
    logic [2:0] inc0, inc1;
    pesc_pkg::pesc_events_t events;
    pesc_pkg::pesc_events_t e;
    int fail_count = 0;
    int check_count = 0;

    pesc_top #(.CNT_W(40)) pesc_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .events_i(events),
        .sel0_i(sel0), .sel1_i(sel1), .count0_o(count0), .count1_o(count1),
        .inc0_o(inc0), .inc1_o(inc1));
    pesc_src_model pesc_src_model_i (.clk_i(clk_i), .events_o(events));

    // 100 MHz core clock
    always #5 clk_i = ~clk_i;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // Idle two clocks so request and halt history clear before the baseline
    task automatic start(input logic [5:0] s0, input logic [5:0] s1);
        sel0 = s0;
        sel1 = s1;
        pesc_src_model_i.apply('0, 2);
        base0 = count0;
        base1 = count1;
    endtask : start

    // Growth since the baseline, then a fresh baseline
    task automatic delta(input logic [39:0] d0, input logic [39:0] d1);
        chk(count0 - base0, d0);
        chk(count1 - base1, d1);
        base0 = count0;
        base1 = count1;
    endtask : delta

    task automatic go(input int n);
        pesc_src_model_i.apply(e, n);
    endtask : go

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_instr();
        start(pesc_pkg::EV_INSTR_EXEC, pesc_pkg::EV_INSTR_SECOND);
        e = '0;
        e.first_retire = 1'b1;
        e.second_retire = 1'b1;
        pesc_src_model_i.hold(e, 1'b0);
        #1;
        chk({37'h0, inc0}, 40'h2);
        chk({37'h0, inc1}, 40'h1);
        @(posedge clk_i);
        #1;
        delta(40'h2, 40'h1);
        e = '0;
        e.fault_invoke = 1'b1;
        e.maskable_interrupt_request_taken = 1'b1;
        go(1);
        delta(40'h2, 40'h0);
        e = '0;
        e.first_retire = 1'b1;
        go(1);
        e.string_repeat = 1'b1;
        go(3);
        delta(40'h1, 40'h0);
        e = '0;
        e.first_retire = 1'b1;
        e.halt_instruction = 1'b1;
        e.halted = 1'b1;
        go(1);
        e.halt_instruction = 1'b0;
        go(4);
        delta(40'h1, 40'h0);
    endtask : s_instr

    task automatic s_bus();
        start(pesc_pkg::EV_BUS_CYCLE_CLKS, pesc_pkg::EV_IO_CYCLE);
        e = '0;
        e.bus_busy = 1'b1;
        go(2);
        e = '0;
        e.hold_acknowledge = 1'b1;
        go(1);
        e = '0;
        e.address_hold_request = 1'b1;
        go(1);
        e = '0;
        e.bus_backoff = 1'b1;
        go(1);
        delta(40'h5, 40'h0);
        e = '0;
        e.bus_cycle_start = 1'b1;
        e.cycle_io = 1'b1;
        go(2);
        e.cycle_restart = 1'b1;
        go(1);
        delta(40'h0, 40'h2);
    endtask : s_bus

    task automatic s_stall();
        start(pesc_pkg::EV_WBUF_FULL_STALL, pesc_pkg::EV_READ_WAIT_STALL);
        e = '0;
        e.wbuf_full_stall = 1'b1;
        go(2);
        e.io_access = 1'b1;
        go(1);
        e = '0;
        e.read_wait_stall = 1'b1;
        go(1);
        e = '0;
        e.dtlb_miss_stall = 1'b1;
        go(1);
        e = '0;
        e.fill_read_stall = 1'b1;
        go(1);
        delta(40'h2, 40'h3);
        start(pesc_pkg::EV_EM_WRITE_STALL, pesc_pkg::EV_LOCKED_CYCLE);
        e = '0;
        e.em_write_stall = 1'b1;
        go(3);
        e = '0;
        e.bus_cycle_start = 1'b1;
        e.cycle_locked_read = 1'b1;
        go(1);
        e.split_cycle_flag = 1'b1;
        go(1);
        e.cycle_restart = 1'b1;
        go(1);
        delta(40'h3, 40'h3);
    endtask : s_stall

    task automatic s_misc();
        start(pesc_pkg::EV_NC_READ, pesc_pkg::EV_AGI_STALL);
        e = '0;
        e.bus_cycle_start = 1'b1;
        e.cycle_nc_read = 1'b1;
        go(1);
        e.cycle_restart = 1'b1;
        go(1);
        e.cycle_restart = 1'b0;
        e.cycle_io = 1'b1;
        e.agi_first = 1'b1;
        e.agi_second = 1'b1;
        go(1);
        e = '0;
        e.agi_second = 1'b1;
        go(1);
        delta(40'h1, 40'h3);
        start(pesc_pkg::EV_FLOPS, pesc_pkg::EV_HW_MASKABLE_INTERRUPT_REQUEST);
        e = '0;
        e.fp_ops = 3'h3;
        go(1);
        e.fp_ops = 3'h2;
        e.fp_excluded_exc = 1'b1;
        go(1);
        e = '0;
        e.hw_maskable_interrupt_request_taken = 1'b1;
        go(2);
        delta(40'h3, 40'h2);
    endtask : s_misc

    // Counter 1 sits on codes that must add nothing while busy events run
    task automatic s_bkpt();
        logic [5:0] bad [4] = '{6'h20, 6'h21, 6'h2b, 6'h15};
        for (int k = 0; k < 4; k++) begin
            start(pesc_pkg::EV_BKPT_ZERO + 6'(k), bad[k]);
            e = '0;
            e.breakpoint_match_pins = 4'h1 << k;
            e.first_retire = 1'b1;
            e.second_retire = 1'b1;
            go(1);
            e.bkpt_code_second = 1'b1;
            go(1);
            e.bkpt_enabled = 1'b1;
            go(1);
            e.breakpoint_match_pins = ~(4'h1 << k);
            go(1);
            delta(40'h2, 40'h0);
        end
    endtask : s_bkpt

    task automatic s_own();
        start(pesc_pkg::EV_BUS_OWNERSHIP, pesc_pkg::EV_BUS_OWNERSHIP);
        e = '0;
        e.private_bus_request = 1'b1;
        go(3);
        e.private_bus_grant = 1'b1;
        go(1);
        delta(40'h3, 40'h1);
        e = '0;
        e.private_modified_snoop_hit = 1'b1;
        go(1);
        e = '0;
        e.modified_line_snoop_hit = 1'b1;
        go(1);
        e = '0;
        go(1);
        e.private_bus_grant = 1'b1;
        go(1);
        delta(40'h3, 40'h0);
    endtask : s_own

    // Last: the closing same-line miss leaves a fill open
    task automatic s_data();
        start(pesc_pkg::EV_DATA_RW, pesc_pkg::EV_DATA_MISS);
        e = '0;
        e.data_access = 2'h2;
        go(1);
        e.data_miss = 2'h1;
        e.data_tlb_proc = 1'b1;
        go(1);
        e.data_tlb_proc = 1'b0;
        e.data_io = 1'b1;
        go(1);
        delta(40'h2, 40'h0);
        pesc_src_model_i.fill(0);
        delta(40'h0, 40'h1);
        pesc_src_model_i.fill(2);
        delta(40'h0, 40'h1);
        e = '0;
        e.data_miss = 2'h1;
        e.miss_same_line = 1'b1;
        go(1);
        delta(40'h0, 40'h1);
    endtask : s_data

    // ****************************************
    // Sequence, watchdog and verdict
    // ****************************************
    task automatic wrap_up();
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (10) @(posedge clk_i);
        #1;
        chk(count0, 40'h0);
        resetn_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        s_instr();
        s_bus();
        s_stall();
        s_misc();
        s_bkpt();
        s_own();
        s_data();
        wrap_up();
    end

    // About 125 clocks of work; far more means a hang
    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
